// [bench/ssm_spi_primary.sv]
// Serial primary model for one port of the supervisor
`default_nettype none
module ssm_spi_primary (
  output logic sclk,
  output logic sel_n,
  output logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclk = 1'b0;
    sel_n = 1'b1;
    mosi = 1'b0;
  end
  // Always a whole 24-bit packet; clock stands low outside frames
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
    logic [23:0] bits;
    bits = {cmd, wd};
    rd = 16'h0000;
    sel_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      mosi <= bits[i];
      #400 sclk <= 1'b1;
      if (i < 16) rd[i] = miso;
      #400 sclk <= 1'b0;
    end
    #400 sel_n <= 1'b1;
    mosi <= ~mosi;
  endtask
endmodule
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench of the system supervisor
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, arst_n, req, main_ok, hb, sq, seqclk, rd, wr;
  logic [3:0] rail;
  logic [1:0] twarn, terr, miso, miso_oe_n;
  wire [1:0] sclk, sel_n, mosi;
  logic [4:0] addr;
  logic [31:0] wdata, rdata;
  logic waitreq, crg, rail_en, ctl_rst_n, park_n, irq;
  logic [15:0] q;
  int n_errors = 0;
  int tests_run = 0;
  int mdl [8];
  ssm_supervisor dut (.core_clk(core_clk), .arst_n(arst_n), .system_on_request(req),
    .main_supply_sense(main_ok), .rail_good(rail), .heartbeat_watch_in(hb),
    .sequence_watch_in(sq), .sequencer_clock_in(seqclk), .temp_warn_in(twarn),
    .temp_err_in(terr), .spi_sclk(sclk), .port_select_n(sel_n), .spi_mosi(mosi),
    .spi_miso(miso), .spi_miso_oe_n(miso_oe_n), .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(waitreq),
    .combined_rail_good(crg), .rail_enable(rail_en), .controller_reset_n(ctl_rst_n),
    .park_n(park_n), .irq(irq));
  ssm_spi_primary p0 (.sclk(sclk[0]), .sel_n(sel_n[0]), .mosi(mosi[0]), .miso(miso[0]));
  ssm_spi_primary p1 (.sclk(sclk[1]), .sel_n(sel_n[1]), .mosi(mosi[1]), .miso(miso[1]));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) seqclk <= ~seqclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // One bus cycle, held until waitrequest is seen low
  task automatic av(input logic w, input logic [2:0] a, input logic [15:0] d,
                    output logic [15:0] r);
    int k;
    @(posedge core_clk);
    addr <= {a, 2'b00};
    rd <= ~w;
    wr <= w;
    wdata <= {16'h0000, d};
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (waitreq !== 1'b0 && k < 50);
    r = rdata[15:0];
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 50) begin
      n_errors++;
      results();
    end
  endtask
  task automatic rchk(input logic [2:0] a);
    av(1'b0, a, 16'h0000, q);
    chk("register", q, mdl[a]);
  endtask
  task automatic wreg(input logic [2:0] a, input logic [15:0] d);
    av(1'b1, a, d, q);
    if (a < 5) mdl[a] = (a == 0) ? (d & 16'h000F) : d;
  endtask
  task automatic wait_state(input logic [4:0] s);
    for (int i = 0; i < 1000; i++) begin
      av(1'b0, 3'h6, 16'h0000, q);
      if (q[4:0] === s) break;
    end
    chk("state", q[4:0], s);
    if (q[4:0] !== s) results();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    req = 1'b0;
    main_ok = 1'b1;
    hb = 1'b0;
    sq = 1'b0;
    seqclk = 1'b0;
    rail = 4'hF;
    twarn = 2'h0;
    terr = 2'h0;
    addr = 5'h00;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    mdl = '{0, 'hA, 'h64, 'hA, 'h64, 0, 0, 0};
    void'($urandom(56691));
    cyc(20);
    chk("waitreq", waitreq, 1);
    chk("ctl_rst_n", ctl_rst_n, 0);
    arst_n <= 1'b1;
    cyc(2);
    chk("miso_oe_n", miso_oe_n, 2'h3);
    for (int a = 0; a < 8; a++) if (a != 6) rchk(3'(a));
    repeat (8) begin
      rail <= 4'($urandom);
      cyc(5);
      chk("rail_good", crg, &rail);
    end
    rail <= 4'hF;
    // Warning holds power-on back and shows on the monitor port
    twarn <= 2'b01;
    req <= 1'b1;
    cyc(100);
    av(1'b0, 3'h6, 16'h0000, q);
    chk("hold_off", q[4:0], 5'h01);
    p1.xfer(8'h06, 16'h0000, q);
    chk("mon_warn", q[8], 1);
    chk("irq_masked", irq, 0);
    wreg(3'h0, 16'h0004);
    cyc(3);
    chk("irq_on", irq, 1);
    twarn <= 2'b00;
    cyc(5);
    wreg(3'h5, 16'h0004);
    cyc(3);
    chk("irq_clear", irq, 0);
    wait_state(5'h04);
    chk("ctl_rst_n", ctl_rst_n, 1);
    chk("rail_en", rail_en, 1);
    p0.xfer(8'h81, 16'h0004, q);
    mdl[1] = 4;
    p1.xfer(8'h81, 16'hFFFF, q);
    wreg(3'h2, 16'h0008);
    wreg(3'h3, 16'h0002);
    wreg(3'h4, 16'h0008);
    wreg(3'h0, 16'h0003);
    for (int a = 0; a < 5; a++) rchk(3'(a));
    // Heartbeat edges two ticks apart: too early
    hb <= 1'b1;
    cyc(5);
    hb <= 1'b0;
    cyc(5);
    hb <= 1'b1;
    for (int i = 0; i < 10 && ctl_rst_n; i++) cyc(1);
    chk("wd_off", ctl_rst_n, 0);
    cyc(5);
    hb <= 1'b0;
    av(1'b0, 3'h5, 16'h0000, q);
    chk("status", q, 16'h0001);
    wreg(3'h0, 16'h0002);
    wreg(3'h5, 16'h0003);
    repeat (4) begin
      sq <= 1'b1;
      cyc(3);
      sq <= 1'b0;
      cyc(27);
    end
    av(1'b0, 3'h5, 16'h0000, q);
    chk("status", q, 16'h0000);
    cyc(80);
    av(1'b0, 3'h5, 16'h0000, q);
    chk("status", q, 16'h0002);
    wreg(3'h5, 16'h0003);
    wreg(3'h0, 16'h0000);
    wait_state(5'h04);
    av(1'b0, 3'h6, 16'h0000, q);
    chk("ratio", q[15:12], 4'h1);
    terr <= 2'b10;
    wait_state(5'h10);
    terr <= 2'b00;
    cyc(50);
    av(1'b0, 3'h6, 16'h0000, q);
    chk("shut_hold", q[4:0], 5'h10);
    req <= 1'b0;
    wait_state(5'h01);
    req <= 1'b1;
    wait_state(5'h04);
    main_ok <= 1'b0;
    wait_state(5'h08);
    chk("park_n", park_n, 0);
    results();
  end
endmodule
`default_nettype wire

// [hw/ssm_supervisor.sv]
// System supervisor: power state, monitors, watchdogs, serial ports, bus slave
//
// Local design decisions: register access over Avalon-MM and the address map.
`default_nettype none
module ssm_supervisor (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic system_on_request,
  input wire logic main_supply_sense,
  input wire logic [3:0] rail_good,
  input wire logic heartbeat_watch_in,
  input wire logic sequence_watch_in,
  input wire logic sequencer_clock_in,
  input wire logic [1:0] temp_warn_in,
  input wire logic [1:0] temp_err_in,
  input wire logic [1:0] spi_sclk,
  input wire logic [1:0] port_select_n,
  input wire logic [1:0] spi_mosi,
  output logic [1:0] spi_miso,
  output logic [1:0] spi_miso_oe_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic combined_rail_good,
  output logic rail_enable,
  output logic controller_reset_n,
  output logic park_n,
  output logic irq
);
  typedef struct packed {
    logic [ssm_pkg::SY_W-1:0] s1;
    logic [ssm_pkg::SY_W-1:0] s2;
    logic seqclk_prev;
    logic [1:0] sclk_prev;
    logic [1:0] sel_prev;
    ssm_pkg::ssm_state_t state;
    logic [9:0] park_cnt;
    logic [2:0] tick_div;
    logic tick;
    logic [4:0] ctrl;
    logic [1:0][15:0] wd_open;
    logic [1:0][15:0] wd_close;
    logic [3:0] status;
    logic [3:0] ratio_ticks;
    logic [8:0] ratio_edges;
    logic [3:0] ratio;
    logic [1:0][4:0] bit_cnt;
    logic [1:0][15:0] sh_in;
    logic [1:0][7:0] cmd;
    logic [1:0][15:0] sh_out;
    logic [1:0] miso;
    logic [1:0] oe_n;
    logic wait_r;
    logic [15:0] rdata;
    logic good;
    logic rail_en;
    logic rst_n;
    logic park_n;
    logic irq;
  } ssm_top_t;

  ssm_top_t q;
  ssm_top_t n;
  logic [ssm_pkg::SY_W-1:0] raw;
  logic [1:0] wd_err;
  logic warn;
  logic terr;
  logic wd_fault;

  assign raw = {spi_mosi, port_select_n, spi_sclk, temp_err_in, temp_warn_in, rail_good,
                sequencer_clock_in, sequence_watch_in, heartbeat_watch_in,
                main_supply_sense, system_on_request};
  assign warn = |q.s2[ssm_pkg::SY_WARN +: 2]; // R12
  assign terr = |q.s2[ssm_pkg::SY_TERR +: 2]; // R12
  assign wd_fault = (wd_err[0] & q.ctrl[ssm_pkg::CTRL_WD1_EN])
                  | (wd_err[1] & q.ctrl[ssm_pkg::CTRL_WD2_EN]);

  ////////////////////////////////////////////////////////////////////////////
  // Watchdogs

  genvar gw;
  generate
    for (gw = 0; gw < 2; gw++) begin : g_wd
      ssm_watchdog u_wd ( // R6
        .core_clk(core_clk),
        .arst_n(arst_n),
        .tick(q.tick),
        .enable(q.ctrl[ssm_pkg::CTRL_WD1_EN + gw]),
        .watch_in(q.s2[ssm_pkg::SY_WD + gw]), // R11
        .open_ticks(q.wd_open[gw]),
        .close_ticks(q.wd_close[gw]),
        .err(wd_err[gw])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux, shared by both serial ports and the bus

  function automatic logic [15:0] reg_read(logic [6:0] idx, ssm_top_t s);
    logic [15:0] d;
    d = 16'h0000;
    if (idx == ssm_pkg::REG_CTRL) begin
      d = {11'h000, s.ctrl};
    end else if (idx == ssm_pkg::REG_STATUS) begin
      d = {12'h000, s.status};
    end else if (idx == ssm_pkg::REG_MONITOR) begin
      d = {s.ratio, // R17 R24
           s.s2[ssm_pkg::SY_TERR + 1], s.s2[ssm_pkg::SY_WARN + 1],
           s.s2[ssm_pkg::SY_TERR], s.s2[ssm_pkg::SY_WARN], // R16
           s.good, s.s2[ssm_pkg::SY_ON], s.s2[ssm_pkg::SY_MAIN], s.state};
    end else begin
      for (int w = 0; w < 2; w++) begin
        if (idx == ssm_pkg::REG_WD_BASE + 7'(2 * w)) begin
          d = s.wd_open[w];
        end
        if (idx == ssm_pkg::REG_WD_BASE + 7'(2 * w + 1)) begin
          d = s.wd_close[w];
        end
      end
    end
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [1:0] we;
    logic [1:0][6:0] widx;
    logic [1:0][15:0] wdat;
    logic [3:0] clr;
    logic [3:0] set;
    logic [15:0] word;
    logic rise;
    logic fall;
    logic sel;
    we = 2'h0;
    widx = '0;
    wdat = '0;
    clr = 4'h0;
    set = 4'h0;
    word = 16'h0000;
    rise = 1'b0;
    fall = 1'b0;
    sel = 1'b0;
    n = q;
    n.s1 = raw; // R25
    n.s2 = q.s1; // R25
    n.seqclk_prev = q.s2[ssm_pkg::SY_SEQCLK];
    n.sclk_prev = q.s2[ssm_pkg::SY_SCLK +: 2];
    n.sel_prev = q.s2[ssm_pkg::SY_SEL +: 2];
    n.ctrl[ssm_pkg::CTRL_CYCLE] = 1'b0;

    // Internal oscillator rate as a one-cycle enable
    n.tick = 1'b0;
    if (q.tick_div == ssm_pkg::TICK_LAST) begin
      n.tick_div = 3'h0;
      n.tick = 1'b1;
    end else begin
      n.tick_div = q.tick_div + 3'h1;
    end

    // Clock ratio: external edges over a window of internal ticks
    if (q.s2[ssm_pkg::SY_SEQCLK] && !q.seqclk_prev && q.ratio_edges != ssm_pkg::RATIO_EDGE_MAX) begin
      n.ratio_edges = q.ratio_edges + 9'h001; // R17
    end
    if (q.tick) begin
      if (q.ratio_ticks == ssm_pkg::RATIO_WIN_LAST) begin
        n.ratio_ticks = 4'h0;
        n.ratio_edges = 9'h000;
        if (|(q.ratio_edges >> (ssm_pkg::RATIO_SHIFT + 4))) begin
          n.ratio = ssm_pkg::RATIO_FULL; // R24
        end else begin
          n.ratio = 4'(q.ratio_edges >> ssm_pkg::RATIO_SHIFT); // R24
        end
      end else begin
        n.ratio_ticks = q.ratio_ticks + 4'h1;
      end
    end

    // Serial target ports: mode 0, MSB first, 8-bit command then 16 data bits
    for (int p = 0; p < 2; p++) begin
      sel = ~q.s2[ssm_pkg::SY_SEL + p];
      rise = q.s2[ssm_pkg::SY_SCLK + p] & ~q.sclk_prev[p];
      fall = ~q.s2[ssm_pkg::SY_SCLK + p] & q.sclk_prev[p];
      if (!sel) begin
        n.bit_cnt[p] = 5'h00; // R20
        n.oe_n[p] = 1'b1; // R20
      end else begin
        n.oe_n[p] = 1'b0;
        if (q.sel_prev[p]) begin
          n.bit_cnt[p] = 5'h00; // R20
        end else if (rise && q.bit_cnt[p] != ssm_pkg::SPI_FRAME_BITS) begin
          word = {q.sh_in[p][14:0], q.s2[ssm_pkg::SY_MOSI + p]}; // R21
          n.sh_in[p] = word;
          n.bit_cnt[p] = q.bit_cnt[p] + 5'h01;
          if (q.bit_cnt[p] == ssm_pkg::SPI_CMD_LAST) begin
            n.cmd[p] = word[7:0];
            n.sh_out[p] = reg_read(word[6:0], q); // R19 R16
          end
          if (q.bit_cnt[p] == ssm_pkg::SPI_FRAME_LAST && p == ssm_pkg::PORT_CTL
              && q.cmd[p][ssm_pkg::SPI_WR_BIT]) begin
            we[0] = 1'b1; // R18
            widx[0] = q.cmd[p][6:0];
            wdat[0] = word;
          end
        end
        if (fall && q.bit_cnt[p] > ssm_pkg::SPI_CMD_LAST) begin
          n.miso[p] = q.sh_out[p][15]; // R18
          n.sh_out[p] = {q.sh_out[p][14:0], 1'b0};
        end
      end
    end

    // Bus slave: one wait cycle, then the answer
    n.wait_r = 1'b1;
    if ((avs_read || avs_write) && q.wait_r) begin
      n.wait_r = 1'b0;
      n.rdata = avs_read ? reg_read({4'h0, avs_address[4:2]}, q) : 16'h0000;
    end
    if (avs_write && !q.wait_r) begin
      we[1] = 1'b1;
      widx[1] = {4'h0, avs_address[4:2]};
      wdat[1] = avs_writedata[15:0];
    end

    // Register writes, bus after control port
    for (int s = 0; s < 2; s++) begin
      if (we[s]) begin
        if (widx[s] == ssm_pkg::REG_CTRL) begin
          n.ctrl = wdat[s][4:0];
        end
        if (widx[s] == ssm_pkg::REG_STATUS) begin
          clr = clr | wdat[s][3:0];
        end
        for (int w = 0; w < 2; w++) begin
          if (widx[s] == ssm_pkg::REG_WD_BASE + 7'(2 * w)) begin
            n.wd_open[w] = wdat[s]; // R7
          end
          if (widx[s] == ssm_pkg::REG_WD_BASE + 7'(2 * w + 1)) begin
            n.wd_close[w] = wdat[s]; // R7
          end
        end
      end
    end

    // Sticky flags, a new event beats a clear
    set[ssm_pkg::ST_WD1] = wd_err[0];
    set[ssm_pkg::ST_WD2] = wd_err[1];
    set[ssm_pkg::ST_WARN] = warn;
    set[ssm_pkg::ST_TERR] = terr;
    n.status = (q.status & ~clr) | set; // R26

    // Power state
    n.good = &q.s2[ssm_pkg::SY_RAIL +: 4]; // R5
    unique case (q.state)
      ssm_pkg::ST_OFF: begin
        if (q.s2[ssm_pkg::SY_ON] && q.s2[ssm_pkg::SY_MAIN] && !warn) begin
          n.state = ssm_pkg::ST_RAMP; // R2 R3 R15
        end
      end
      ssm_pkg::ST_RAMP: begin
        if (terr) begin
          n.state = ssm_pkg::ST_SHUT; // R14
        end else if (!q.s2[ssm_pkg::SY_MAIN]) begin
          n.state = ssm_pkg::ST_OFF;
        end else if (q.good && !warn) begin
          n.state = ssm_pkg::ST_ACTIVE; // R15
        end
      end
      ssm_pkg::ST_ACTIVE: begin
        if (terr) begin
          n.state = ssm_pkg::ST_SHUT; // R14
        end else if (wd_fault) begin
          n.state = ssm_pkg::ST_OFF; // R23
        end else if (!q.s2[ssm_pkg::SY_MAIN] || !q.s2[ssm_pkg::SY_ON] || !q.good
                     || q.ctrl[ssm_pkg::CTRL_CYCLE]) begin
          n.state = ssm_pkg::ST_PARK; // R4
          n.park_cnt = 10'h000;
        end
      end
      ssm_pkg::ST_PARK: begin
        if (terr) begin
          n.state = ssm_pkg::ST_SHUT; // R14
        end else if (q.park_cnt == ssm_pkg::PARK_LAST) begin
          n.state = ssm_pkg::ST_OFF; // R4
        end else begin
          n.park_cnt = q.park_cnt + 10'h001;
        end
      end
      ssm_pkg::ST_SHUT: begin
        if (!q.s2[ssm_pkg::SY_ON]) begin
          n.state = ssm_pkg::ST_OFF; // R14
        end
      end
      default: begin
        n.state = ssm_pkg::ST_OFF;
      end
    endcase
    n.rail_en = n.state inside {ssm_pkg::ST_RAMP, ssm_pkg::ST_ACTIVE, ssm_pkg::ST_PARK};
    n.rst_n = n.state == ssm_pkg::ST_ACTIVE;
    n.park_n = n.state != ssm_pkg::ST_PARK; // R4
    n.irq = (|n.status[ssm_pkg::ST_WD1 +: 2] & n.ctrl[ssm_pkg::CTRL_WD_IE])
          | (|n.status[ssm_pkg::ST_WARN +: 2] & n.ctrl[ssm_pkg::CTRL_WARN_IE]); // R13 R26
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0; // R1
      q.state <= ssm_pkg::ST_OFF; // R1
      q.ctrl <= ssm_pkg::CTRL_RST;
      q.wd_open <= {2{ssm_pkg::WD_OPEN_RST}};
      q.wd_close <= {2{ssm_pkg::WD_CLOSE_RST}};
      q.sclk_prev <= 2'h0;
      q.sel_prev <= 2'h3;
      q.s1 <= '0;
      q.s2 <= '0;
      // Select lines idle high, no false frame after reset
      q.s1[ssm_pkg::SY_SEL +: 2] <= 2'h3;
      q.s2[ssm_pkg::SY_SEL +: 2] <= 2'h3;
      q.oe_n <= 2'h3;
      q.wait_r <= 1'b1;
      q.park_n <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign spi_miso = q.miso;
  assign spi_miso_oe_n = q.oe_n;
  assign avs_readdata = {16'h0000, q.rdata};
  assign avs_waitrequest = q.wait_r;
  assign combined_rail_good = q.good;
  assign rail_enable = q.rail_en;
  assign controller_reset_n = q.rst_n;
  assign park_n = q.park_n;
  assign irq = q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic we_ctl_any;
  assign we_ctl_any = ~q.s2[ssm_pkg::SY_SEL + ssm_pkg::PORT_CTL];

  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  stay_off_a: assert property (q.state == ssm_pkg::ST_OFF && !q.s2[ssm_pkg::SY_ON]
    |=> q.state == ssm_pkg::ST_OFF) // R3
    else $error("left off state while request low");
  start_up_a: assert property (q.state == ssm_pkg::ST_OFF && q.s2[ssm_pkg::SY_ON]
    && q.s2[ssm_pkg::SY_MAIN] && !warn |=> q.state == ssm_pkg::ST_RAMP && rail_enable) // R2
    else $error("on request did not start power-up");
  warn_hold_a: assert property (warn && q.state inside {ssm_pkg::ST_OFF, ssm_pkg::ST_RAMP}
    && !terr |=> q.state inside {ssm_pkg::ST_OFF, ssm_pkg::ST_RAMP}) // R15
    else $error("power-up advanced under temperature warning");
  brown_park_a: assert property (q.state == ssm_pkg::ST_ACTIVE && !q.s2[ssm_pkg::SY_MAIN]
    && !terr && !wd_fault |=> q.state == ssm_pkg::ST_PARK ##1 !park_n [*8]) // R4
    else $error("brown-out did not park");
  park_end_a: assert property (q.state == ssm_pkg::ST_PARK && q.park_cnt == ssm_pkg::PARK_LAST
    && !terr |=> q.state == ssm_pkg::ST_OFF && park_n && !rail_enable) // R4
    else $error("parking did not end in off state");
  temp_shut_a: assert property (terr && q.state inside {ssm_pkg::ST_RAMP, ssm_pkg::ST_ACTIVE,
    ssm_pkg::ST_PARK} |=> q.state == ssm_pkg::ST_SHUT) // R14
    else $error("over-temperature did not shut down");
  shut_hold_a: assert property (q.state == ssm_pkg::ST_SHUT && q.s2[ssm_pkg::SY_ON]
    |=> q.state == ssm_pkg::ST_SHUT) // R14
    else $error("shutdown left without request toggle");
  wd_off_a: assert property (q.state == ssm_pkg::ST_ACTIVE && wd_fault && !terr
    |=> q.state == ssm_pkg::ST_OFF ##1 !controller_reset_n) // R23
    else $error("watchdog error did not force off state");
  rail_comb_a: assert property (!(&q.s2[ssm_pkg::SY_RAIL +: 4]) |=> !combined_rail_good) // R5
    else $error("rail fault not shown on combined good");
  sticky_a: assert property (q.status[ssm_pkg::ST_WD1] && !avs_write && !(we_ctl_any)
    |=> q.status[ssm_pkg::ST_WD1]) // R26
    else $error("watchdog flag dropped without clear");
  warn_irq_a: assert property (warn && q.ctrl[ssm_pkg::CTRL_WARN_IE] && !avs_write
    && !we_ctl_any |=> irq) // R13
    else $error("enabled warning gave no interrupt");
  frame_end_a: assert property (q.s2[ssm_pkg::SY_SEL + ssm_pkg::PORT_MON]
    |=> spi_miso_oe_n[ssm_pkg::PORT_MON] && q.bit_cnt[ssm_pkg::PORT_MON] == 5'h00) // R20
    else $error("monitor port drives outside its frame");
endmodule
`default_nettype wire

// [hw/ssm_watchdog.sv]
// Windowed watchdog: one input, one error pulse
`default_nettype none
module ssm_watchdog (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic enable,
  input wire logic watch_in,
  input wire logic [15:0] open_ticks,
  input wire logic [15:0] close_ticks,
  output logic err
);
  typedef struct packed {
    logic prev;
    logic armed;
    logic [15:0] cnt;
    logic err;
  } ssm_wd_t;

  ssm_wd_t q;
  ssm_wd_t n;
  logic rise;

  assign rise = watch_in & ~q.prev;
  assign err = q.err;

  always_comb begin
    n = q;
    n.err = 1'b0;
    n.prev = watch_in;
    if (!enable) begin
      n.armed = 1'b0;
      n.cnt = 16'h0000;
    end else if (rise) begin
      if (q.armed && q.cnt < open_ticks) begin
        n.err = 1'b1; // R9
      end
      n.armed = 1'b1; // R8
      n.cnt = 16'h0000; // R8
    end else if (q.armed && tick) begin
      if (q.cnt >= close_ticks) begin
        n.err = 1'b1; // R10
        n.armed = 1'b0;
      end else begin
        n.cnt = q.cnt + 16'h0001; // R7
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  early_edge_a: assert property (enable && rise && q.armed && q.cnt < open_ticks |=> err) // R9
    else $error("early edge did not raise error");
  late_close_a: assert property (enable && !rise && q.armed && tick && q.cnt >= close_ticks
    |=> err ##1 !err) // R10
    else $error("closed window did not raise one error pulse");
  restart_a: assert property (enable && rise |=> q.armed && q.cnt == 16'h0000) // R8
    else $error("edge did not restart window timing");
  in_window_a: assert property (enable && rise && q.armed && q.cnt >= open_ticks
    && q.cnt <= close_ticks |=> !err) // R7
    else $error("edge inside window flagged as error");
endmodule
`default_nettype wire

// [shared/ssm_pkg.sv]
// Constants, register map and state codes of the system supervisor
// Behaviour
// R1: Supply monitor reset holds all logic asynchronously
// R2: On request high means on, low off
// R3: After reset sample request, stay off while low
// R4: Brown-out parks mirrors then goes power-safe
// R5: Rail monitors combine into one good signal
// R6: Two fully independent windowed watchdogs
// R7: Programmed values set window open and close
// R8: Rising edge starts and restarts window timing
// R9: Edge before window opens raises error
// R10: Window closing without edge raises error
// R11: Partner drives heartbeat and sequence start lines
// R12: Each temperature monitor gives warning and error
// R13: Warning may raise interrupt when configured
// R14: Over-temperature shuts down until request toggles
// R15: No power-on progress while warning active
// R16: Temperature bits readable on both serial ports
// R17: Internal versus external clock ratio readable
// R18: Two serial targets, control port reads writes
// R19: Monitor port read-only, reads every register
// R20: Frame spans select low to select high
// R21: Monitor port captures data on clock rise
// R22: Partner always sends complete monitor transactions
// R23: Enabled watchdog error returns system to off
// R24: Ratio is four bits, mid-scale means nominal
// R25: Asynchronous inputs pass two flip-flops first
// R26: Sticky error flags, software cleared, drive interrupt
`default_nettype none
package ssm_pkg;
  localparam int unsigned CORE_HZ = 10_000_000;
  localparam int unsigned TICK_HZ = 2_000_000;
  localparam int unsigned TICK_DIV = CORE_HZ / TICK_HZ;
  localparam logic [2:0] TICK_LAST = 3'(TICK_DIV - 1);
  localparam int unsigned PARK_TIME_US = 100;
  localparam int unsigned PARK_CYC = PARK_TIME_US * (CORE_HZ / 1_000_000);
  localparam logic [9:0] PARK_LAST = 10'(PARK_CYC - 1);
  localparam logic [3:0] RATIO_WIN_LAST = 4'h8;
  localparam int unsigned RATIO_SHIFT = 4;
  localparam logic [8:0] RATIO_EDGE_MAX = 9'h1FF;
  localparam logic [3:0] RATIO_FULL = 4'hF;
  localparam logic [4:0] SPI_CMD_LAST = 5'h07;
  localparam logic [4:0] SPI_FRAME_LAST = 5'h17;
  localparam logic [4:0] SPI_FRAME_BITS = 5'h18;
  localparam int unsigned SPI_WR_BIT = 7;
  localparam int unsigned PORT_CTL = 0;
  localparam int unsigned PORT_MON = 1;
  localparam logic [6:0] REG_CTRL = 7'h00;
  localparam logic [6:0] REG_WD_BASE = 7'h01;
  localparam logic [6:0] REG_STATUS = 7'h05;
  localparam logic [6:0] REG_MONITOR = 7'h06;
  localparam int unsigned CTRL_WD1_EN = 0;
  localparam int unsigned CTRL_WD2_EN = 1;
  localparam int unsigned CTRL_WARN_IE = 2;
  localparam int unsigned CTRL_WD_IE = 3;
  localparam int unsigned CTRL_CYCLE = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam int unsigned ST_WD1 = 0;
  localparam int unsigned ST_WD2 = 1;
  localparam int unsigned ST_WARN = 2;
  localparam int unsigned ST_TERR = 3;
  localparam logic [15:0] WD_OPEN_RST = 16'h000A;
  localparam logic [15:0] WD_CLOSE_RST = 16'h0064;
  localparam int unsigned SY_ON = 0;
  localparam int unsigned SY_MAIN = 1;
  localparam int unsigned SY_WD = 2;
  localparam int unsigned SY_SEQCLK = 4;
  localparam int unsigned SY_RAIL = 5;
  localparam int unsigned SY_WARN = 9;
  localparam int unsigned SY_TERR = 11;
  localparam int unsigned SY_SCLK = 13;
  localparam int unsigned SY_SEL = 15;
  localparam int unsigned SY_MOSI = 17;
  localparam int unsigned SY_W = 19;
  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_RAMP = 5'h02,
    ST_ACTIVE = 5'h04,
    ST_PARK = 5'h08,
    ST_SHUT = 5'h10
  } ssm_state_t;
endpackage
`default_nettype wire
